// file: voice_serial_audio_pkg.sv
// constants, register map and field layout of the serial voice audio master
package voice_serial_audio_pkg;

    // clock and frame timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned FRAME_HZ        = 8_000;
    localparam int unsigned PCM_SHORT_BITS  = 17;
    localparam int unsigned PCM_LONG_BITS   = 18;
    localparam int unsigned NORM_FRAME_BITS = 32;
    localparam int unsigned SLOT_BITS       = 16;
    localparam int unsigned SAMPLE_W        = 16;
    localparam int unsigned ACC_W           = 27;

    // half-bit tick steps: two clock edges per bit time
    localparam logic [ACC_W-1:0] STEP_PCM_SHORT = ACC_W'(2 * PCM_SHORT_BITS * FRAME_HZ);
    localparam logic [ACC_W-1:0] STEP_PCM_LONG  = ACC_W'(2 * PCM_LONG_BITS * FRAME_HZ);
    localparam logic [ACC_W-1:0] STEP_NORMAL    = ACC_W'(2 * NORM_FRAME_BITS * FRAME_HZ);

    // bit counter values
    localparam logic [4:0] LAST_PCM_SHORT = 5'h10;
    localparam logic [4:0] LAST_PCM_LONG  = 5'h11;
    localparam logic [4:0] LAST_NORMAL    = 5'h1f;
    localparam logic [4:0] SYNC_SHORT     = 5'h01;
    localparam logic [4:0] SYNC_LONG      = 5'h02;
    localparam logic [4:0] SLOT_LEN       = 5'h10;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] GAIN_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;

    // control register fields
    localparam int unsigned CTRL_ENABLE    = 0;
    localparam int unsigned CTRL_NORMAL    = 1;
    localparam int unsigned CTRL_SYNC_LONG = 2;
    localparam int unsigned CTRL_TX_FALL   = 3;
    localparam int unsigned CTRL_MSB_DELAY = 4;
    localparam int unsigned CTRL_UL_DIGI   = 5;
    localparam int unsigned CTRL_DL_DIGI   = 6;
    localparam int unsigned CTRL_HANDSFREE = 7;
    localparam int unsigned CTRL_TX_FILT   = 8;
    localparam int unsigned CTRL_RX_FILT   = 9;
    localparam int unsigned CTRL_W         = 10;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

    // gain register: tx gain in [7:0], rx gain in [15:8], unsigned q4.4
    localparam int unsigned GAIN_W     = 8;
    localparam int unsigned GAIN_FRAC  = 4;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 8'h10;

    // status register: last received sample [15:0], bit counter [20:16], strobe [21]
    localparam int unsigned STAT_CNT_LSB = 16;
    localparam int unsigned STAT_STROBE  = 21;

endpackage

// file: voice_serial_tick_gen.sv
// fractional rate generator giving one-cycle ticks at an average programmable rate
`timescale 1ns/1ps
module voice_serial_tick_gen #(
    parameter int unsigned ACC_W  = 27,
    parameter int unsigned CLK_HZ = 40_000_000
) (
    // clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // rate control
    input  wire logic             run_i,
    input  wire logic [ACC_W-1:0] step_i,
    // tick out
    output logic                  tick_o
);

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic             tick;
    } tick_state_s;

    localparam logic [ACC_W:0] MODULUS = (ACC_W+1)'(CLK_HZ);

    tick_state_s q_r;
    tick_state_s q_nxt;

    always_comb begin
        logic [ACC_W:0] sum;
        sum = {1'b0, q_r.acc} + {1'b0, step_i};
        q_nxt = q_r;
        q_nxt.tick = 1'b0;
        if (!run_i) begin
            q_nxt.acc = '0;
        end else if (sum >= MODULUS) begin
            q_nxt.acc = ACC_W'(sum - MODULUS);
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.acc = sum[ACC_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= '0;
        end else if (ce_i) begin
            q_r <= q_nxt;
        end
    end

    assign tick_o = q_r.tick;

endmodule

// file: voice_serial_audio_master.sv
// serial voice audio port master with wishbone registers
//
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module voice_serial_audio_master #(
    parameter int unsigned ADDR_W   = 8,
    parameter int unsigned SAMPLE_W = voice_serial_audio_pkg::SAMPLE_W
) (
    // clock, reset, enable
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    // wishbone slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    // serial link
    output logic                     frame_align_strobe_o,
    output logic                     bit_clk_o,
    output logic                     tx_data_o,
    input  wire logic                rx_data_i,
    // voice processing side
    input  wire logic [SAMPLE_W-1:0] dl_sample_i,
    input  wire logic [SAMPLE_W-1:0] tone_sample_i,
    input  wire logic                tone_active_i,
    output logic [SAMPLE_W-1:0]      ul_sample_o,
    output logic                     ul_valid_o,
    output logic                     frame_tick_o,
    // path routing indications
    output logic                     analog_gain_bypass_o,
    output logic                     hands_free_processing_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    localparam int unsigned CW = voice_serial_audio_pkg::CTRL_W;
    localparam int unsigned GW = voice_serial_audio_pkg::GAIN_W;
    localparam int unsigned AW = voice_serial_audio_pkg::ACC_W;

    typedef struct packed {
        logic [1:0]          rxd_sync;
        logic                bclk;
        logic [4:0]          bit_cnt;
        logic                strobe;
        logic                txd;
        logic [SAMPLE_W-1:0] tx_word;
        logic [SAMPLE_W-1:0] rx_sr;
        logic [SAMPLE_W-1:0] ul_sample;
        logic                ul_valid;
        logic                frame_tick;
        logic [SAMPLE_W-1:0] dl_prev;
        logic [SAMPLE_W-1:0] ul_prev;
        logic [SAMPLE_W-1:0] rx_last;
        logic [CW-1:0]       ctrl;
        logic [GW-1:0]       tx_gain;
        logic [GW-1:0]       rx_gain;
        logic                ack;
        logic [31:0]         rdata;
    } master_state_s;

    localparam master_state_s STATE_RESET = '{
        rxd_sync:   2'h0,
        bclk:       1'b0,
        bit_cnt:    voice_serial_audio_pkg::LAST_NORMAL,
        strobe:     1'b0,
        txd:        1'b0,
        tx_word:    '0,
        rx_sr:      '0,
        ul_sample:  '0,
        ul_valid:   1'b0,
        frame_tick: 1'b0,
        dl_prev:    '0,
        ul_prev:    '0,
        rx_last:    '0,
        ctrl:       voice_serial_audio_pkg::CTRL_RESET,
        tx_gain:    voice_serial_audio_pkg::GAIN_RESET,
        rx_gain:    voice_serial_audio_pkg::GAIN_RESET,
        ack:        1'b0,
        rdata:      32'h0000_0000
    };

    master_state_s q_r;
    master_state_s q_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    // sample arithmetic

    function automatic logic [SAMPLE_W-1:0] sat_f(input logic signed [SAMPLE_W+9:0] v);
        logic signed [SAMPLE_W+9:0] hi;
        logic signed [SAMPLE_W+9:0] lo;
        hi = (SAMPLE_W+10)'($signed({1'b0, {(SAMPLE_W-1){1'b1}}}));
        lo = (SAMPLE_W+10)'($signed({1'b1, {(SAMPLE_W-1){1'b0}}}));
        if (v > hi) begin
            sat_f = {1'b0, {(SAMPLE_W-1){1'b1}}};
        end else if (v < lo) begin
            sat_f = {1'b1, {(SAMPLE_W-1){1'b0}}};
        end else begin
            sat_f = v[SAMPLE_W-1:0];
        end
    endfunction

    // q4.4 gain with saturation
    function automatic logic [SAMPLE_W-1:0] gain_f(input logic [SAMPLE_W-1:0] x,
                                                   input logic [GW-1:0]       g);
        logic signed [SAMPLE_W+9:0] p;
        p = (SAMPLE_W+10)'($signed(x) * $signed({1'b0, g}));
        gain_f = sat_f(p >>> voice_serial_audio_pkg::GAIN_FRAC);
    endfunction

    // two-tap smoothing low-pass
    function automatic logic [SAMPLE_W-1:0] filt_f(input logic [SAMPLE_W-1:0] x,
                                                   input logic [SAMPLE_W-1:0] prev);
        logic signed [SAMPLE_W:0] s;
        s = $signed({x[SAMPLE_W-1], x}) + $signed({prev[SAMPLE_W-1], prev});
        filt_f = s[SAMPLE_W:1];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // mode decode

    logic          enable;
    logic          normal;
    logic          sync_long;
    logic          launch_fall;
    logic          msb_delay;
    logic [4:0]    last_bit;
    logic [4:0]    sync_len;
    logic [AW-1:0] step;
    logic          half_tick;

    always_comb begin
        enable      = q_r.ctrl[voice_serial_audio_pkg::CTRL_ENABLE];
        normal      = q_r.ctrl[voice_serial_audio_pkg::CTRL_NORMAL];
        sync_long   = q_r.ctrl[voice_serial_audio_pkg::CTRL_SYNC_LONG];
        msb_delay   = q_r.ctrl[voice_serial_audio_pkg::CTRL_MSB_DELAY];
        launch_fall = normal && q_r.ctrl[voice_serial_audio_pkg::CTRL_TX_FALL];
        sync_len    = sync_long ? voice_serial_audio_pkg::SYNC_LONG
                                : voice_serial_audio_pkg::SYNC_SHORT;
        if (normal) begin
            last_bit = voice_serial_audio_pkg::LAST_NORMAL;
            step     = voice_serial_audio_pkg::STEP_NORMAL;
        end else if (sync_long) begin
            last_bit = voice_serial_audio_pkg::LAST_PCM_LONG;
            step     = voice_serial_audio_pkg::STEP_PCM_LONG;
        end else begin
            last_bit = voice_serial_audio_pkg::LAST_PCM_SHORT;
            step     = voice_serial_audio_pkg::STEP_PCM_SHORT;
        end
    end

    // two ticks per bit time give both clock edges
    voice_serial_tick_gen #(
        .ACC_W  (AW),
        .CLK_HZ (voice_serial_audio_pkg::CLK_HZ)
    ) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .run_i  (enable),
        .step_i (step),
        .tick_o (half_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // bit position helpers

    // position within a slot after the optional one-bit delay
    function automatic logic [4:0] norm_pos_f(input logic [4:0] b, input logic dly);
        norm_pos_f = b - {4'h0, dly};
    endfunction

    function automatic logic strobe_f(input logic [4:0] b, input logic nrm,
                                      input logic [4:0] slen);
        if (nrm) begin
            strobe_f = (b < voice_serial_audio_pkg::SLOT_LEN);
        end else begin
            strobe_f = (b < slen);
        end
    endfunction

    function automatic logic tx_bit_f(input logic [4:0]          b,
                                      input logic                nrm,
                                      input logic                dly,
                                      input logic [4:0]          slen,
                                      input logic [SAMPLE_W-1:0] w);
        logic [4:0] pos;
        logic [4:0] d;
        pos = norm_pos_f(b, dly);
        d   = b - slen;
        if (nrm) begin
            tx_bit_f = w[4'hf - pos[3:0]];
        end else if (b == 5'h00) begin
            tx_bit_f = 1'b0;
        end else if (b < slen) begin
            tx_bit_f = w[SAMPLE_W-1];
        end else begin
            tx_bit_f = w[4'hf - d[3:0]];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic          launch;
    logic          capture;
    logic          rx_in_slot;
    logic [4:0]    b_next;
    logic [4:0]    cap_pos;
    logic [SAMPLE_W-1:0] dl_proc;
    logic [SAMPLE_W-1:0] ul_proc;
    logic          wb_req;
    logic          addr_hit;

    always_comb begin
        q_nxt = q_r;
        q_nxt.rxd_sync   = {q_r.rxd_sync[0], rx_data_i};
        q_nxt.ul_valid   = 1'b0;
        q_nxt.frame_tick = 1'b0;

        // launch and capture fall on opposite clock edges
        launch  = half_tick && (launch_fall ? q_r.bclk : !q_r.bclk);
        capture = half_tick && (launch_fall ? !q_r.bclk : q_r.bclk);

        b_next = (q_r.bit_cnt >= last_bit) ? 5'h00 : q_r.bit_cnt + 5'h01;
        cap_pos = norm_pos_f(q_r.bit_cnt, msb_delay);
        if (normal) begin
            rx_in_slot = !cap_pos[4];
        end else begin
            rx_in_slot = (q_r.bit_cnt >= sync_len);
        end

        // downlink: filter, gain, tone mix
        dl_proc = q_r.ctrl[voice_serial_audio_pkg::CTRL_TX_FILT]
                ? filt_f(dl_sample_i, q_r.dl_prev) : dl_sample_i;
        dl_proc = gain_f(dl_proc, q_r.tx_gain);
        if (tone_active_i) begin
            dl_proc = sat_f((SAMPLE_W+10)'($signed(dl_proc))
                          + (SAMPLE_W+10)'($signed(tone_sample_i)));
        end
        // uplink: filter, gain
        ul_proc = q_r.ctrl[voice_serial_audio_pkg::CTRL_RX_FILT]
                ? filt_f(q_r.rx_sr, q_r.ul_prev) : q_r.rx_sr;
        ul_proc = gain_f(ul_proc, q_r.rx_gain);

        if (!enable) begin
            q_nxt.bclk    = 1'b0;
            q_nxt.strobe  = 1'b0;
            q_nxt.txd     = 1'b0;
            q_nxt.bit_cnt = voice_serial_audio_pkg::LAST_NORMAL;
        end else begin
            if (half_tick) begin
                q_nxt.bclk = !q_r.bclk;
            end
            if (capture && rx_in_slot) begin
                q_nxt.rx_sr = {q_r.rx_sr[SAMPLE_W-2:0], q_r.rxd_sync[1]};
            end
            if (launch) begin
                q_nxt.bit_cnt = b_next;
                if (b_next == 5'h00) begin
                    // frame boundary: load next word, hand over received one
                    q_nxt.tx_word    = dl_proc;
                    q_nxt.dl_prev    = dl_sample_i;
                    q_nxt.ul_sample  = ul_proc;
                    q_nxt.ul_prev    = q_r.rx_sr;
                    q_nxt.rx_last    = q_r.rx_sr;
                    q_nxt.ul_valid   = 1'b1;
                    q_nxt.frame_tick = 1'b1;
                    q_nxt.txd = tx_bit_f(b_next, normal, msb_delay, sync_len, dl_proc);
                end else begin
                    q_nxt.txd = tx_bit_f(b_next, normal, msb_delay, sync_len,
                                         q_r.tx_word);
                end
                q_nxt.strobe = strobe_f(b_next, normal, sync_len);
            end
        end

        // wishbone: registered ack one cycle after the request
        wb_req   = wb_cyc_i && wb_stb_i && !q_r.ack;
        addr_hit = (wb_adr_i[7:0] == voice_serial_audio_pkg::CTRL_OFS)
                || (wb_adr_i[7:0] == voice_serial_audio_pkg::GAIN_OFS)
                || (wb_adr_i[7:0] == voice_serial_audio_pkg::STATUS_OFS);
        q_nxt.ack   = wb_req;
        q_nxt.rdata = 32'h0000_0000;
        if (wb_req && wb_we_i && addr_hit) begin
            if (wb_adr_i[7:0] == voice_serial_audio_pkg::CTRL_OFS) begin
                if (wb_sel_i[0]) begin
                    q_nxt.ctrl[7:0] = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    q_nxt.ctrl[CW-1:8] = wb_dat_i[CW-1:8];
                end
            end else if (wb_adr_i[7:0] == voice_serial_audio_pkg::GAIN_OFS) begin
                if (wb_sel_i[0]) begin
                    q_nxt.tx_gain = wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    q_nxt.rx_gain = wb_dat_i[15:8];
                end
            end
        end else if (wb_req && !wb_we_i) begin
            case (wb_adr_i[7:0])
                voice_serial_audio_pkg::CTRL_OFS: begin
                    q_nxt.rdata[CW-1:0] = q_r.ctrl;
                end
                voice_serial_audio_pkg::GAIN_OFS: begin
                    q_nxt.rdata[15:0] = {q_r.rx_gain, q_r.tx_gain};
                end
                voice_serial_audio_pkg::STATUS_OFS: begin
                    q_nxt.rdata[SAMPLE_W-1:0] = q_r.rx_last;
                    q_nxt.rdata[voice_serial_audio_pkg::STAT_CNT_LSB +: 5] = q_r.bit_cnt;
                    q_nxt.rdata[voice_serial_audio_pkg::STAT_STROBE] = q_r.strobe;
                end
                default: begin
                    q_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= STATE_RESET;
        end else if (ce_i) begin
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_dat_o             = q_r.rdata;
    assign wb_ack_o             = q_r.ack;
    assign frame_align_strobe_o = q_r.strobe;
    assign bit_clk_o            = q_r.bclk;
    assign tx_data_o            = q_r.txd;
    assign ul_sample_o          = q_r.ul_sample;
    assign ul_valid_o           = q_r.ul_valid;
    assign frame_tick_o         = q_r.frame_tick;
    assign analog_gain_bypass_o = q_r.ctrl[voice_serial_audio_pkg::CTRL_UL_DIGI]
                               && q_r.ctrl[voice_serial_audio_pkg::CTRL_DL_DIGI];
    assign hands_free_processing_o = q_r.ctrl[voice_serial_audio_pkg::CTRL_HANDSFREE]
                                  && analog_gain_bypass_o;

endmodule

// file: voice_serial_audio_master_asserts.sv
// checker for the voice serial audio master ports
`timescale 1ns/1ps
module voice_serial_audio_master_asserts (
    // bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // link and routing
    input wire logic        frame_align_strobe_o,
    input wire logic        bit_clk_o,
    input wire logic        tx_data_o,
    input wire logic        frame_tick_o,
    input wire logic        analog_gain_bypass_o,
    input wire logic        hands_free_processing_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [9:0]  ctrl_r;
    logic [13:0] cnt_r;
    logic        arm_r;
    logic        wr_ctrl;
    // control writes land at the edge that takes the request, the same edge that raises ack
    assign wr_ctrl = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
                  && wb_adr_i == voice_serial_audio_pkg::CTRL_OFS;
    // shadow of the control word and clocks since the last frame start
    always_ff @(posedge clk_i) begin
        cnt_r <= frame_tick_o ? 14'h0 : cnt_r + 14'h1;
        if (rst_i || wr_ctrl)
            arm_r <= 1'b0;
        else if (frame_tick_o)
            arm_r <= 1'b1;
        if (rst_i)
            ctrl_r <= '0;
        else if (wr_ctrl)
            ctrl_r <= {wb_sel_i[1] ? wb_dat_i[9:8] : ctrl_r[9:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : ctrl_r[7:0]};
    end
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("stray data");
    sync_tick_a: assert property ($rose(frame_align_strobe_o) |-> frame_tick_o)
        else $error("strobe off frame start");
    frame_period_a: assert property (frame_tick_o && arm_r |->
        cnt_r inside {[14'd4996:14'd5002]}) else $error("frame not 125 us");
    sync_low_a: assert property ($rose(frame_align_strobe_o) && !ctrl_r[1] |-> !tx_data_o)
        else $error("first sync bit high");
    clock_idle_a: assert property ((!ctrl_r[0]) [*3] |-> !bit_clk_o)
        else $error("clock runs while off");
    launch_edge_a: assert property ($changed(tx_data_o) && ctrl_r[0] && !wr_ctrl |->
        $changed(bit_clk_o) && bit_clk_o == !(ctrl_r[1] && ctrl_r[3])) else $error("tx edge");
    strobe_edge_a: assert property ($changed(frame_align_strobe_o) && ctrl_r[0] && !wr_ctrl
        |-> $changed(bit_clk_o)) else $error("strobe edge");
    bypass_a: assert property ($stable(ctrl_r) |->
        analog_gain_bypass_o == (ctrl_r[5] && ctrl_r[6])) else $error("bypass level");
    hands_free_a: assert property ($stable(ctrl_r) |->
        hands_free_processing_o == (ctrl_r[5] && ctrl_r[6] && ctrl_r[7])) else $error("hf level");
endmodule
bind voice_serial_audio_master voice_serial_audio_master_asserts u_chk (.*);

// file: voice_codec_model.sv
// slave codec model: follows clock and strobe, returns one fixed word per frame
`timescale 1ns/1ps
module voice_codec_model #(
    parameter logic [15:0] WORD = 16'h9c35
) (
    input  wire logic clk_i,
    input  wire logic bit_clk_i,
    input  wire logic strobe_i,
    output logic      rx_data_o
);
    logic        prev_r = 1'b0;
    logic [15:0] sh_r   = 16'h0;
    initial rx_data_o = 1'b0;
    // data moves on the falling clock edge, word reloaded while strobe is high
    always @(posedge clk_i) begin
        prev_r <= bit_clk_i;
        if (prev_r && !bit_clk_i) begin
            rx_data_o <= strobe_i ? WORD[15] : sh_r[15];
            sh_r      <= strobe_i ? {WORD[14:0], ~WORD[0]} : {sh_r[14:0], ~sh_r[15]};
        end
    end
endmodule

// file: voice_serial_audio_master_bench.sv
// self-checking bench for the voice serial audio master
`timescale 1ns/1ps
module voice_serial_audio_master_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, w;
    logic        wb_ack_o, frame_align_strobe_o, bit_clk_o, tx_data_o, rx_data_i;
    logic [15:0] dl_sample_i = 16'h0, tone_sample_i = 16'h0, ul_sample_o;
    logic        tone_active_i = 1'b0, ul_valid_o, frame_tick_o;
    logic        analog_gain_bypass_o, hands_free_processing_o;
    int          err_count = 0, checked = 0;
    localparam logic [9:0]  CT [8] = '{10'h001, 10'h005, 10'h003, 10'h00b, 10'h013, 10'h001,
                                       10'h001, 10'h101};
    localparam logic [15:0] DL [8] = '{16'ha5c3, 16'h8001, 16'h1234, 16'hbeef, 16'h8421, 16'h0123,
                                       16'h7f00, 16'h0100};
    localparam logic [15:0] TN [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0100, 16'h0200,
                                       16'h0};
    // last entry: tx filter averages the new sample with the previous frame's 7f00
    localparam logic [31:0] EX [8] = '{32'h0000_a5c3, 32'h0001_8001, 32'h1234_1234, 32'hbeef_beef,
                                       32'hc210_c210, 32'h0000_0346, 32'h0000_7fff, 32'h0000_4000};
    always #12.5 clk_i = ~clk_i;
    voice_serial_audio_master u_dut (.*);
    voice_codec_model #(.WORD(16'h9c35)) u_codec (.clk_i(clk_i), .bit_clk_i(bit_clk_o),
        .strobe_i(frame_align_strobe_o), .rx_data_o(rx_data_i));
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int t;
        t = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
        do begin
            @(posedge clk_i);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 50);
        if (wb_ack_o !== 1'b1) err_count++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick_wait();
        int t;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (frame_tick_o !== 1'b1 && t < 12000);
        cmp("ul valid", 32'h1, {31'h0, ul_valid_o});
    endtask
    // collects n launched bits, starting at the frame start
    task automatic grab(input int n, input logic lv);
        int k, t;
        logic p;
        k = 0;
        t = 0;
        w = 32'h0;
        p = bit_clk_o;
        while (k < n && t < 12000) begin
            @(posedge clk_i);
            #1;
            t++;
            if (bit_clk_o !== p && bit_clk_o === lv && (k > 0 || frame_tick_o === 1'b1)) begin
                w = {w[30:0], tx_data_o};
                k++;
            end
            p = bit_clk_o;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // about twice the expected run of ten frames
    initial begin
        #2_500_000;
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h00, 32'h0, 4'hf);
        cmp("ctrl reset", 32'h0, q);
        bus(1'b0, 8'h04, 32'h0, 4'hf);
        cmp("gain reset", 32'h0000_1010, q);
        bus(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
        bus(1'b0, 8'h0c, 32'h0, 4'hf);
        cmp("unmapped", 32'h0, q);
        bus(1'b1, 8'h00, 32'h0000_00e0, 4'hf);
        repeat (3) @(posedge clk_i);
        cmp("bypass", 32'h1, {31'h0, analog_gain_bypass_o});
        cmp("hands free", 32'h1, {31'h0, hands_free_processing_o});
        bus(1'b1, 8'h00, 32'h0000_03a0, 4'h1);
        bus(1'b0, 8'h00, 32'h0, 4'hf);
        cmp("ctrl lanes", 32'h0000_00a0, q);
        repeat (3) @(posedge clk_i);
        cmp("bypass", 32'h0, {31'h0, analog_gain_bypass_o});
        cmp("hands free", 32'h0, {31'h0, hands_free_processing_o});
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h04, (i == 5) ? 32'h0000_1020 : 32'h0000_1010, 4'hf);
            dl_sample_i <= DL[i];
            tone_sample_i <= TN[i];
            tone_active_i <= (TN[i] != 16'h0);
            bus(1'b1, 8'h00, {22'h0, CT[i]}, 4'hf);
            grab(CT[i][1] ? 32 : (CT[i][2] ? 18 : 17), !(CT[i][1] && CT[i][3]));
            cmp("tx frame", EX[i], w);
            if (i < 2) begin
                tick_wait();
                tick_wait();
                bus(1'b0, 8'h08, 32'h0, 4'hf);
                cmp("rx word", 32'h0000_9c35, {16'h0, q[15:0]});
                cmp("ul sample", 32'h0000_9c35, {16'h0, ul_sample_o});
            end
            bus(1'b1, 8'h00, 32'h0, 4'hf);
            $display("frame test %0d done", i);
        end
        end_of_test();
    end
endmodule
